// *** logic/cfj_pkg.sv ***
// cfj_pkg: constants and types shared by the configuration/test pin block
// assumes a 250 MHz core clock; the test clock is sampled, never used as a clock
package cfj_pkg;

    localparam int unsigned CORE_CLK_PS   = 4000;   // core clock period in ps
    localparam int unsigned CRST_MIN_NS   = 320;    // least low width of reconfig request, ns
    // least time rounds up to whole core cycles
    localparam int unsigned CRST_MIN_CYC  = (CRST_MIN_NS * 1000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
    localparam int unsigned CRST_CNT_W    = 8;      // width of the pulse-width counter
    // synchroniser reset, {tck, tms, tdi, done line, request}: the test clock
    // idles low so no false edge follows reset, pulled-up pins read one, and
    // the done line reads held low so nothing can enter user mode early
    localparam logic [4:0]  PIN_RST_VAL   = 5'h0d;

    localparam int unsigned IR_LEN        = 4;      // instruction register length
    localparam logic [3:0]  IR_BYPASS     = 4'hf;   // all ones selects bypass
    localparam logic [3:0]  IR_IDCODE     = 4'h3;   // identification register
    localparam logic [3:0]  IR_ENTERUSER  = 4'h7;   // leave configuration, go to user mode
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;   // fixed capture pattern, low bits 01
    localparam logic [31:0] IDCODE_VAL    = 32'h0000_0001; // arbitrary value, lsb one
    localparam int unsigned ID_LEN        = 32;     // identification register length

    localparam int unsigned CFG_LOAD_CYC  = 64;     // length of an internal configuration load
    localparam int unsigned CFG_CNT_W     = 7;      // width of the load counter

    // sixteen-state test access port controller, one-hot
    typedef enum logic [15:0] {
        CFJ_RESET   = 16'h0001,
        CFJ_IDLE    = 16'h0002,
        CFJ_SEL_DR  = 16'h0004,
        CFJ_CAP_DR  = 16'h0008,
        CFJ_SH_DR   = 16'h0010,
        CFJ_EX1_DR  = 16'h0020,
        CFJ_PAU_DR  = 16'h0040,
        CFJ_EX2_DR  = 16'h0080,
        CFJ_UPD_DR  = 16'h0100,
        CFJ_SEL_IR  = 16'h0200,
        CFJ_CAP_IR  = 16'h0400,
        CFJ_SH_IR   = 16'h0800,
        CFJ_EX1_IR  = 16'h1000,
        CFJ_PAU_IR  = 16'h2000,
        CFJ_EX2_IR  = 16'h4000,
        CFJ_UPD_IR  = 16'h8000
    } cfj_tap_t;

    // device configuration progress, one-hot
    typedef enum logic [2:0] {
        CFJ_LOADING = 3'h1,
        CFJ_DONE    = 3'h2,
        CFJ_USER    = 3'h4
    } cfj_cfg_t;

    // test port pins as seen by the core (already synchronised)
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } cfj_jtag_in_t;

    // serial output pin with its enable
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } cfj_jtag_out_t;

endpackage : cfj_pkg

// *** logic/cfj_sync.sv ***
// cfj_sync: two-flop synchroniser for a bus of pin inputs
// assumes inputs are asynchronous to core_clk; reset value given per bit
`timescale 1ns/10ps
module cfj_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] rst_val,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;   // first stage, read only by the second
    logic [W-1:0] sync_q;   // second stage

    // reset takes the constant that the caller ties on rst_val
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta_q <= rst_val;
            sync_q <= rst_val;
        end else if (clk_en) begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule : cfj_sync

// *** logic/cfj_top.sv ***
// cfj_top: configuration-done line, reconfiguration trigger and test access port
// assumes all pins are asynchronous to core_clk; tck is oversampled (tck <= ~30 MHz)
//
// Behaviour
// - done line only pulled low or released
// - release done line only after configuration completes
// - no entry to user mode while done line held low
// - start configuration on request rising edge after least low width
// - request reloads configuration, never resets user logic
// - configuration pins keep role after configuration
// - sample mode-select and data on clock rise
// - update serial output after clock fall
// - undriven mode-select reads as one
// - data input routes to instruction or data register
// - undriven data input reads as one
// - serial output from instruction or data register
// - delay through path equals register length
// - serial output released when not shifting
`timescale 1ns/10ps
module cfj_top
    import cfj_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic config_done_line_in,   // level seen on the shared done line
    output logic      config_done_line_out,  // always 0; only the enable pulls
    output logic      config_done_line_oe,   // high pulls the line low
    input  wire logic reconfig_req_n,        // reconfiguration request, active low
    input  wire logic tck,
    input  wire logic tms,                   // pad pull-up: floating reads 1
    input  wire logic tdi,                   // pad pull-up: floating reads 1
    output logic      tdo,
    output logic      tdo_oe,
    output logic      user_mode,             // device is in user mode
    output logic      cfg_reload             // one-cycle pulse: reload started
);
    cfj_jtag_in_t  pin_s;       // synchronised test pins
    logic          done_s;      // synchronised done line
    logic          req_n_s;     // synchronised request
    logic          tck_q;       // previous synchronised test clock
    logic          tck_rise;    // test clock rising edge seen
    logic          tck_fall;    // test clock falling edge seen
    cfj_tap_t      tap_q;       // controller state
    cfj_tap_t      tap_d;
    logic [IR_LEN-1:0] ir_sh_q; // instruction shift stage
    logic [IR_LEN-1:0] ir_q;    // instruction in force
    logic [ID_LEN-1:0] dr_sh_q; // data shift stage (id or bypass)
    cfj_jtag_out_t out_q;       // serial output pin state
    cfj_cfg_t      cfg_q;       // configuration progress
    logic [CFG_CNT_W-1:0]  load_cnt_q;   // cycles into the current load
    logic [CRST_CNT_W-1:0] low_cnt_q;    // cycles the request has been low
    logic          req_armed_q;          // low long enough to count
    logic          enter_user_q;         // host asked to enter user mode
    logic          req_n_q;              // previous synchronised request
    logic          req_rise;

    // is the path being shifted in this state (output enabled)
    function automatic logic cfj_shifting(input cfj_tap_t s);
        return (s == CFJ_SH_DR) || (s == CFJ_SH_IR);
    endfunction : cfj_shifting

    // selected data register is the one-bit bypass unless id is loaded
    function automatic logic cfj_is_id(input logic [IR_LEN-1:0] ir);
        return ir == IR_IDCODE;
    endfunction : cfj_is_id

    // every pin crosses two flip-flops first; tms/tdi reset to one as if
    // floating on the pull-up, tck to its idle low, the done line to low (held)
    cfj_sync #(.W(5)) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .rst_val  (PIN_RST_VAL),
        .din      ({tck, tms, tdi, config_done_line_in, reconfig_req_n}),
        .dout     ({pin_s.tck, pin_s.tms, pin_s.tdi, done_s, req_n_s})
    );

    // test clock edge detector reads only the synchronised copy; it resets
    // to the idle level of the pin so release of reset shows no edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tck_q <= PIN_RST_VAL[4];
        end else if (clk_en) begin
            tck_q <= pin_s.tck;
        end
    end
    assign tck_rise = clk_en & pin_s.tck & ~tck_q;
    assign tck_fall = clk_en & ~pin_s.tck & tck_q;

    // next controller state from sampled mode-select
    always_comb begin
        tap_d = tap_q;
        unique case (tap_q)
            CFJ_RESET:  tap_d = pin_s.tms ? CFJ_RESET  : CFJ_IDLE;
            CFJ_IDLE:   tap_d = pin_s.tms ? CFJ_SEL_DR : CFJ_IDLE;
            CFJ_SEL_DR: tap_d = pin_s.tms ? CFJ_SEL_IR : CFJ_CAP_DR;
            CFJ_CAP_DR: tap_d = pin_s.tms ? CFJ_EX1_DR : CFJ_SH_DR;
            CFJ_SH_DR:  tap_d = pin_s.tms ? CFJ_EX1_DR : CFJ_SH_DR;
            CFJ_EX1_DR: tap_d = pin_s.tms ? CFJ_UPD_DR : CFJ_PAU_DR;
            CFJ_PAU_DR: tap_d = pin_s.tms ? CFJ_EX2_DR : CFJ_PAU_DR;
            CFJ_EX2_DR: tap_d = pin_s.tms ? CFJ_UPD_DR : CFJ_SH_DR;
            CFJ_UPD_DR: tap_d = pin_s.tms ? CFJ_SEL_DR : CFJ_IDLE;
            CFJ_SEL_IR: tap_d = pin_s.tms ? CFJ_RESET  : CFJ_CAP_IR;
            CFJ_CAP_IR: tap_d = pin_s.tms ? CFJ_EX1_IR : CFJ_SH_IR;
            CFJ_SH_IR:  tap_d = pin_s.tms ? CFJ_EX1_IR : CFJ_SH_IR;
            CFJ_EX1_IR: tap_d = pin_s.tms ? CFJ_UPD_IR : CFJ_PAU_IR;
            CFJ_PAU_IR: tap_d = pin_s.tms ? CFJ_EX2_IR : CFJ_PAU_IR;
            CFJ_EX2_IR: tap_d = pin_s.tms ? CFJ_UPD_IR : CFJ_SH_IR;
            CFJ_UPD_IR: tap_d = pin_s.tms ? CFJ_SEL_DR : CFJ_IDLE;
            default:    tap_d = CFJ_RESET;   // illegal one-hot code recovers
        endcase
    end

    // controller advances only on a test clock rise
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tap_q <= CFJ_RESET;
        end else if (tck_rise) begin
            tap_q <= tap_d;
        end
    end

    // instruction path: capture, shift on rise, load on update
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ir_sh_q <= IR_CAPTURE;
            ir_q    <= IR_IDCODE;
        end else if (tck_rise) begin
            if (tap_q == CFJ_RESET) begin
                ir_q <= IR_IDCODE;                          // reset selects id
            end else if (tap_q == CFJ_CAP_IR) begin
                ir_sh_q <= IR_CAPTURE;
            end else if (tap_q == CFJ_SH_IR) begin
                ir_sh_q <= {pin_s.tdi, ir_sh_q[IR_LEN-1:1]};
            end else if (tap_q == CFJ_UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // data path: id is 32 long, bypass uses only bit 0 so its length is one
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dr_sh_q <= '0;
        end else if (tck_rise) begin
            if (tap_q == CFJ_CAP_DR) begin
                dr_sh_q <= cfj_is_id(ir_q) ? IDCODE_VAL : '0;
            end else if (tap_q == CFJ_SH_DR) begin
                if (cfj_is_id(ir_q)) begin
                    dr_sh_q <= {pin_s.tdi, dr_sh_q[ID_LEN-1:1]};
                end else begin
                    dr_sh_q <= {{(ID_LEN-1){1'b0}}, pin_s.tdi};
                end
            end
        end
    end

    // serial output changes only after a fall; enabled only while shifting
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            out_q <= '0;
        end else if (tck_fall) begin
            out_q.tdo_oe <= cfj_shifting(tap_q);
            out_q.tdo    <= (tap_q == CFJ_SH_IR) ? ir_sh_q[0]
                                                 : dr_sh_q[0];
        end
    end
    assign tdo    = out_q.tdo;
    assign tdo_oe = out_q.tdo_oe;

    // enter-user instruction takes effect at update of instruction
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            enter_user_q <= 1'b0;
        end else if (cfg_reload) begin
            enter_user_q <= 1'b0;
        end else if (tck_rise && tap_q == CFJ_UPD_IR && ir_sh_q == IR_ENTERUSER) begin
            enter_user_q <= 1'b1;
        end
    end

    // request: count low time; a rise only counts after the least width
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            req_n_q     <= 1'b1;
            low_cnt_q   <= '0;
            req_armed_q <= 1'b0;
        end else if (clk_en) begin
            req_n_q <= req_n_s;
            if (req_n_s) begin
                low_cnt_q   <= '0;
                req_armed_q <= 1'b0;
            end else if (low_cnt_q == CRST_CNT_W'(CRST_MIN_CYC - 1)) begin
                req_armed_q <= 1'b1;
            end else begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end
    assign req_rise   = clk_en & req_n_s & ~req_n_q;
    assign cfg_reload = req_rise & req_armed_q;

    // configuration progress; the request restarts only this machine and the enter-user flag,
    // never the test port or anything of the user's
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_q      <= CFJ_LOADING;
            load_cnt_q <= '0;
        end else if (clk_en) begin
            if (cfg_reload) begin
                cfg_q      <= CFJ_LOADING;
                load_cnt_q <= '0;
            end else begin
                unique case (cfg_q)
                    CFJ_LOADING: begin
                        if (load_cnt_q == CFG_CNT_W'(CFG_LOAD_CYC - 1)) begin
                            cfg_q <= CFJ_DONE;
                        end else begin
                            load_cnt_q <= load_cnt_q + 1'b1;
                        end
                    end
                    CFJ_DONE: begin
                        if (done_s && enter_user_q) begin
                            cfg_q <= CFJ_USER;
                        end
                    end
                    CFJ_USER: cfg_q <= CFJ_USER;
                    default:  cfg_q <= CFJ_LOADING;
                endcase
            end
        end
    end

    // done line: low until loaded, then released; never driven high.
    // pins stay dedicated in user mode: no path to general I/O
    assign config_done_line_out = 1'b0;
    assign config_done_line_oe  = (cfg_q == CFJ_LOADING);
    assign user_mode            = (cfg_q == CFJ_USER);

endmodule : cfj_top

// *** verif/cfj_top_asserts.sv ***
// cfj_top_asserts: port-level checks of the done line, reload trigger and tdo
// assumes clk_en held high and every pin asynchronous to core_clk
`timescale 1ns/10ps
module cfj_top_asserts
    import cfj_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic config_done_line_in,
    input wire logic config_done_line_out,
    input wire logic config_done_line_oe,
    input wire logic reconfig_req_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic user_mode,
    input wire logic cfg_reload
);
    logic [7:0] lo_cnt_q;  // pin cycles the request has stayed low

    // count low cycles, saturating; margins cover the synchroniser skew
    always_ff @(posedge core_clk) begin
        if (!nrst || reconfig_req_n) begin
            lo_cnt_q <= 8'h00;
        end else if (lo_cnt_q != 8'hff) begin
            lo_cnt_q <= lo_cnt_q + 8'h01;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_done_out_low: assert property (config_done_line_out == 1'b0)
        else $error("done line driven high");
    a_user_not_loading: assert property (user_mode |-> !config_done_line_oe)
        else $error("user mode while done line pulled");
    a_line_held: assert property ((!config_done_line_in)[*4] |-> !$rose(user_mode))
        else $error("user mode entered with line held low");
    a_reload_clear: assert property (cfg_reload |=> (config_done_line_oe && !user_mode)[*8])
        else $error("reload did not restart loading");
    a_short_ignored: assert property ($rose(reconfig_req_n) && lo_cnt_q < 8'h4e
        |-> (!cfg_reload)[*6])
        else $error("short request pulse accepted");
    a_long_taken: assert property ($rose(reconfig_req_n) && lo_cnt_q > 8'h51
        |-> ##[1:6] cfg_reload)
        else $error("long request pulse not accepted");
    a_tdo_on_fall: assert property ($changed(tdo) || $changed(tdo_oe) |-> !tck)
        else $error("tdo moved while test clock high");
    a_oe_cause: assert property ($rose(config_done_line_oe) |-> $past(cfg_reload))
        else $error("done line pulled without reload");
    a_user_sticky: assert property ($fell(user_mode) |-> $past(cfg_reload))
        else $error("user mode left without reload");

    c_user: cover property ($rose(user_mode));
    c_reload: cover property (cfg_reload);
    c_shift: cover property ($rose(tdo_oe));
endmodule : cfj_top_asserts

bind cfj_top cfj_top_asserts u_cfj_top_asserts (.core_clk(core_clk), .nrst(nrst),
    .clk_en(clk_en), .config_done_line_in(config_done_line_in),
    .config_done_line_out(config_done_line_out), .config_done_line_oe(config_done_line_oe),
    .reconfig_req_n(reconfig_req_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .user_mode(user_mode), .cfg_reload(cfg_reload));

// *** verif/cfj_host.sv ***
// cfj_host: test host plus the done-line pull-up on the far side of cfj_top
// assumes a 125 ns test clock that stands low between frames
`timescale 1ns/10ps
module cfj_host (
    input  wire logic done_oe,    // device pulls the done line low
    input  wire logic hold_low,   // external party holds the line low
    input  wire logic drive,      // host drives tms and tdi
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      done_line,  // wired level after the pull-up
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    logic tms_d;  // value the host puts on tms
    logic tdi_d;  // value the host puts on tdi

    // open drain: any puller wins, otherwise the resistor gives one
    assign done_line = !(done_oe || hold_low);
    // released pins float up through the pad pull-ups
    assign tms = drive ? tms_d : 1'b1;
    assign tdi = drive ? tdi_d : 1'b1;

    initial begin
        tck = 1'b0;
        tms_d = 1'b1;
        tdi_d = 1'b1;
    end

    // one test clock: pins change after the fall, tdo read before the rise
    task automatic bit_cyc(input logic m, input logic d, output logic q);
        tms_d = m;
        tdi_d = d;
        #62.5;
        q = tdo_oe ? tdo : 1'bz;  // released wire shows as z
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : bit_cyc
endmodule : cfj_host

// *** verif/test_cfj_top.sv ***
// test_cfj_top: random and corner tests of the config and test pins
// assumes cfj_host as far side; clk_en held high throughout
`timescale 1ns/10ps
module test_cfj_top;
    import cfj_pkg::*;
    logic        core_clk, nrst, req_n, hold_low, drive;  // bench-driven
    logic        done_in, done_out, done_oe, tck, tms, tdi;
    logic        tdo, tdo_oe, user_mode, cfg_reload;
    logic [31:0] rng_q, got, d;  // random state, scan result, scan data
    logic [3:0]  op;             // random instruction
    logic        q;              // spare tdo sample
    int          error_cnt, checks, cyc;

    cfj_top u_cfj_top (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1),
        .config_done_line_in(done_in), .config_done_line_out(done_out),
        .config_done_line_oe(done_oe), .reconfig_req_n(req_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .user_mode(user_mode),
        .cfg_reload(cfg_reload));
    cfj_host u_cfj_host (.done_oe(done_oe), .hold_low(hold_low), .drive(drive),
        .tdo(tdo), .tdo_oe(tdo_oe), .done_line(done_in), .tck(tck), .tms(tms), .tdi(tdi));

    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // xorshift source, seeded once
    function automatic logic [31:0] rnd();
        rng_q ^= rng_q << 13;
        rng_q ^= rng_q >> 17;
        rng_q ^= rng_q << 5;
        return rng_q;
    endfunction : rnd

    // a one-bit path delays data by one clock, zero shifted in first
    function automatic logic [31:0] byp_exp(input logic [31:0] v, input int n);
        return (v << 1) & ((32'h1 << n) - 32'h1);
    endfunction : byp_exp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // idle -> shift ir or dr, n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic s;
        dout = 32'h0;
        u_cfj_host.bit_cyc(1'b1, 1'b1, s);
        if (ir) u_cfj_host.bit_cyc(1'b1, 1'b1, s);
        u_cfj_host.bit_cyc(1'b0, 1'b1, s);
        u_cfj_host.bit_cyc(1'b0, 1'b1, s);
        for (int i = 0; i < n; i++) begin
            u_cfj_host.bit_cyc(i == n - 1, din[i], s);
            dout[i] = s;
        end
        u_cfj_host.bit_cyc(1'b1, 1'b1, s);
        chk({31'h0, s}, {31'h0, 1'bz});
        u_cfj_host.bit_cyc(1'b0, 1'b1, s);
    endtask : scan

    // hang guard: a run needs well under 20000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("ERROR %0t: timeout", $time);
            end_sim();
        end
    end

    initial begin
        rng_q = 32'h0000_4e1d;
        nrst = 1'b0;
        req_n = 1'b1;
        hold_low = 1'b0;
        drive = 1'b0;
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        repeat (40) @(negedge core_clk);
        chk(done_oe, 1'b1);
        repeat (30) @(negedge core_clk);
        chk({done_out, done_oe, done_in, user_mode}, 4'h2);
        $display("test load done");
        // system side stays quiet for 25 us once the done line is up
        repeat (6250) @(negedge core_clk);
        // load bypass first, so only a floating-one tms can bring id back
        drive = 1'b1;
        u_cfj_host.bit_cyc(1'b0, 1'b1, q);
        scan(1'b1, 4, {28'h0, IR_BYPASS}, got);
        chk(got, {28'h0, IR_CAPTURE});
        drive = 1'b0;
        // floating tms reads one: five clocks reach test-logic-reset
        repeat (5) u_cfj_host.bit_cyc(1'b0, 1'b0, q);
        drive = 1'b1;
        u_cfj_host.bit_cyc(1'b0, 1'b1, q);
        scan(1'b0, 32, rnd(), got);
        chk(got, IDCODE_VAL);
        $display("test id read done");
        for (int k = 0; k < 4; k++) begin
            op = (k == 0) ? IR_BYPASS : 4'(rnd());
            if (op == IR_IDCODE || op == IR_ENTERUSER) op = IR_BYPASS;
            scan(1'b1, 4, {28'h0, op}, got);
            chk(got, {28'h0, IR_CAPTURE});
            d = rnd() & 32'hff;
            scan(1'b0, 8, d, got);
            chk(got, byp_exp(d, 8));
        end
        $display("test bypass done");
        hold_low = 1'b1;
        scan(1'b1, 4, {28'h0, IR_ENTERUSER}, got);
        repeat (50) @(negedge core_clk);
        chk(user_mode, 1'b0);
        hold_low = 1'b0;
        repeat (20) @(negedge core_clk);
        chk(user_mode, 1'b1);
        d = rnd() & 32'hff;
        scan(1'b0, 8, d, got);
        chk(got, byp_exp(d, 8));
        $display("test user mode done");
        for (int k = 0; k < 3; k++) begin
            req_n = 1'b0;
            repeat (10 + rnd() % 60) @(negedge core_clk);
            req_n = 1'b1;
            repeat (20) @(negedge core_clk);
            chk({user_mode, done_oe}, 2'h2);
        end
        req_n = 1'b0;
        repeat (100) @(negedge core_clk); // 400 ns, above the least width
        req_n = 1'b1;
        for (int i = 0; i < 10 && cfg_reload !== 1'b1; i++) @(negedge core_clk);
        chk(cfg_reload, 1'b1);
        @(negedge core_clk);
        chk({done_oe, user_mode}, 2'h2);
        repeat (70) @(negedge core_clk);
        chk({done_oe, user_mode}, 2'h0);
        scan(1'b1, 4, {28'h0, IR_BYPASS}, got);
        chk(got, {28'h0, IR_CAPTURE});
        $display("test reload done");
        end_sim();
    end
endmodule : test_cfj_top
